// ==== speech_frame_defs.svh ====
// speech_frame_defs.svh: constants of the coded speech frame word stream
// assumes: included by bare name from the package and both ends
`ifndef SPEECH_FRAME_DEFS_SVH
`define SPEECH_FRAME_DEFS_SVH
`define WORD_W          16
`define SAMPLE_W        13
`define SAMPLE_PAD_W    3
`define LAR_COUNT       8
`define SUB_COUNT       4
`define PULSE_COUNT     13
`define SUB_WORDS       17
`define FRAME_WORDS     76
`define LAG_W           7
`define GAIN_W          2
`define GRID_W          2
`define AMP_W           6
`define PULSE_W         3
`define LAG_MIN         7'h28
`define LAG_MAX         7'h78
`define FRAME_TIME_MS   20
`define SAMPLES_FRAME   160
`define CLK_HZ          10000000
`define SAMPLE_HZ       8000
`define SAMPLE_CYCLES   (`CLK_HZ / `SAMPLE_HZ)
`endif

// ==== speech_frame_pkg.sv ====
// speech_frame_pkg.sv: types and field widths used by the codec end of the frame link
// assumes: speech_frame_defs.svh on the include path
`default_nettype none
`include "speech_frame_defs.svh"
package speech_frame_pkg;
   typedef logic [`WORD_W-1:0] word_t;
   typedef enum logic [2:0] {
      FLD_LAR   = 3'h0,
      FLD_LAG   = 3'h1,
      FLD_GAIN  = 3'h3,
      FLD_GRID  = 3'h2,
      FLD_AMP   = 3'h6,
      FLD_PULSE = 3'h7
   } field_e;
   // width of a field given its kind and area-ratio index
   function automatic logic [3:0] field_width(input field_e kind, input logic [2:0] larIdx);
      logic [3:0] w;
      w = 4'h0;
      case (kind)
         FLD_LAR:   w = 4'h6 - {2'h0, larIdx[2:1]};
         FLD_LAG:   w = 4'h7;
         FLD_GAIN:  w = 4'h2;
         FLD_GRID:  w = 4'h2;
         FLD_AMP:   w = 4'h6;
         FLD_PULSE: w = 4'h3;
         default:   w = 4'h0;
      endcase
      return w;
   endfunction : field_width
endpackage : speech_frame_pkg
`default_nettype wire

// ==== speech_frame_if.sv ====
// speech_frame_if.sv: word links between codec datapath and test/transport unit
// assumes: one clock; valid/ready handshake on each stream
`default_nettype none
`include "speech_frame_defs.svh"
interface speech_frame_if;
   // encoder input samples, transport to codec
   logic [`WORD_W-1:0] encSample;
   logic               encSampleValid;
   logic               encSampleReady;
   // coded words, codec to transport
   logic [`WORD_W-1:0] codOut;
   logic               codOutValid;
   logic               codOutReady;
   logic               codOutFirst;
   // coded words, transport to codec
   logic [`WORD_W-1:0] codIn;
   logic               codInValid;
   logic               codInReady;
   logic               codInFirst;
   // decoder output samples, codec to transport
   logic [`WORD_W-1:0] decSample;
   logic               decSampleValid;
   logic               decSampleReady;
   modport codec (
      input  encSample, encSampleValid, codOutReady, codIn, codInValid, codInFirst, decSampleReady,
      output encSampleReady, codOut, codOutValid, codOutFirst, codInReady, decSample, decSampleValid
   );
   modport transport (
      output encSample, encSampleValid, codOutReady, codIn, codInValid, codInFirst, decSampleReady,
      input  encSampleReady, codOut, codOutValid, codOutFirst, codInReady, decSample, decSampleValid
   );
endinterface : speech_frame_if
`default_nettype wire

// ==== speech_codec_end.sv ====
// speech_codec_end.sv: codec-side formatter of samples and coded frames
// assumes: datapath supplies whole frames of raw codes; link per speech_frame_if
`default_nettype none
`include "speech_frame_defs.svh"
module speech_codec_end #(
   parameter int FRAME_WORDS = `FRAME_WORDS
) (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   // link
   speech_frame_if.codec                link,
   // datapath: encoder samples out
   output logic [`SAMPLE_W-1:0]         encSampleData,
   output logic                         encSampleStrobe,
   // datapath: encoded frame in, raw code per word
   input  wire logic [`WORD_W-1:0]      encCode,
   input  wire logic                    encCodeValid,
   output logic                         encCodeReady,
   // datapath: decoder codes out
   output logic [`WORD_W-1:0]           decCode,
   output logic [`LAG_W-1:0]            decodedLagValue,
   output logic                         decCodeStrobe,
   output logic                         decFrameDone,
   // datapath: decoder samples in
   input  wire logic [`SAMPLE_W-1:0]    decSampleData,
   input  wire logic                    decSampleValid,
   output logic                         decSampleReady
);
   // elaboration check: field walk serves only the 76-word frame
   if (FRAME_WORDS != `FRAME_WORDS)
   begin : g_frame_check
      $error("frame length must be 76 words");
   end

   // ---------------------------------------------------------------
   // field position within a frame
   // ---------------------------------------------------------------
   function automatic logic [3:0] width_at(input logic [6:0] idx);
      logic [6:0] sub;
      logic [4:0] pos;
      sub = 7'h0;
      pos = 5'h0;
      if (idx < 7'h8)
         return speech_frame_pkg::field_width(speech_frame_pkg::FLD_LAR, idx[2:0]);
      sub = idx - 7'h8;
      pos = 5'(sub % 7'(`SUB_WORDS));
      case (pos)
         5'h0:    return speech_frame_pkg::field_width(speech_frame_pkg::FLD_LAG, 3'h0);
         5'h1:    return speech_frame_pkg::field_width(speech_frame_pkg::FLD_GAIN, 3'h0);
         5'h2:    return speech_frame_pkg::field_width(speech_frame_pkg::FLD_GRID, 3'h0);
         5'h3:    return speech_frame_pkg::field_width(speech_frame_pkg::FLD_AMP, 3'h0);
         default: return speech_frame_pkg::field_width(speech_frame_pkg::FLD_PULSE, 3'h0);
      endcase
   endfunction : width_at

   function automatic logic is_lag(input logic [6:0] idx);
      logic [6:0] sub;
      sub = idx - 7'h8;
      return (idx >= 7'h8) && ((sub % 7'(`SUB_WORDS)) == 7'h0);
   endfunction : is_lag

   function automatic logic [`WORD_W-1:0] mask_of(input logic [3:0] w);
      return 16'((17'h1 << w) - 17'h1);
   endfunction : mask_of

   // ---------------------------------------------------------------
   // encoder sample input
   // ---------------------------------------------------------------
   assign link.encSampleReady = 1'b1;
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         encSampleData   <= '0;
         encSampleStrobe <= 1'b0;
      end
      else
      begin
         encSampleStrobe <= link.encSampleValid;
         if (link.encSampleValid)
            encSampleData <= link.encSample[`WORD_W-1:`SAMPLE_PAD_W];
      end
   end

   // ---------------------------------------------------------------
   // encoded frame output
   // ---------------------------------------------------------------
   logic [6:0]         encIdx;
   logic               outFull;
   logic [`WORD_W-1:0] outWord;
   logic               outFirst;
   wire  [3:0]         encWidth = width_at(encIdx);
   wire  [`WORD_W-1:0] encMasked = encCode & mask_of(encWidth);
   wire  [`LAG_W-1:0]  rawLag = encCode[`LAG_W-1:0];
   wire  [`LAG_W-1:0]  clampLag = (rawLag < `LAG_MIN) ? `LAG_MIN :
                                  (rawLag > `LAG_MAX) ? `LAG_MAX : rawLag;
   wire  [`WORD_W-1:0] encWord = is_lag(encIdx) ? {9'h0, clampLag} : encMasked;
   wire                encTake = encCodeValid && encCodeReady;
   wire                encLast = encIdx == 7'(FRAME_WORDS - 1);
   assign encCodeReady     = !outFull || link.codOutReady;
   assign link.codOut      = outWord;
   assign link.codOutValid = outFull;
   assign link.codOutFirst = outFirst;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         encIdx   <= '0;
         outFull  <= 1'b0;
         outWord  <= '0;
         outFirst <= 1'b0;
      end
      else
      begin
         if (encTake)
         begin
            outWord  <= encWord;
            outFirst <= encIdx == 7'h0;
            encIdx   <= encLast ? 7'h0 : encIdx + 7'h1;
         end
         if (encTake)
            outFull <= 1'b1;
         else if (link.codOutReady)
            outFull <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // decoder frame input: never stalls, any code accepted
   // ---------------------------------------------------------------
   logic [6:0] decIdx;
   wire  [6:0] decPos = link.codInFirst ? 7'h0 : decIdx;
   wire  [`WORD_W-1:0] decMasked = link.codIn & mask_of(width_at(decPos));
   assign link.codInReady = 1'b1;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         decIdx          <= '0;
         decCode         <= '0;
         decodedLagValue <= '0;
         decCodeStrobe   <= 1'b0;
         decFrameDone    <= 1'b0;
      end
      else
      begin
         decCodeStrobe <= link.codInValid;
         decFrameDone  <= link.codInValid && decPos == 7'(FRAME_WORDS - 1);
         if (link.codInValid)
         begin
            decCode <= decMasked;
            if (is_lag(decPos))
               decodedLagValue <= decMasked[`LAG_W-1:0];
            decIdx <= (decPos == 7'(FRAME_WORDS - 1)) ? 7'h0 : decPos + 7'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // decoder sample output
   // ---------------------------------------------------------------
   logic               smpFull;
   logic [`WORD_W-1:0] smpWord;
   assign decSampleReady      = !smpFull || link.decSampleReady;
   assign link.decSample      = smpWord;
   assign link.decSampleValid = smpFull;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         smpFull <= 1'b0;
         smpWord <= '0;
      end
      else
      begin
         if (decSampleValid && decSampleReady)
         begin
            smpWord <= {decSampleData, `SAMPLE_PAD_W'(0)};
            smpFull <= 1'b1;
         end
         else if (link.decSampleReady)
            smpFull <= 1'b0;
      end
   end
endmodule : speech_codec_end
`default_nettype wire

// ==== speech_transport_end.sv ====
// speech_transport_end.sv: test/transport side that feeds and captures words
// assumes: user side presents raw 13-bit samples and 16-bit coded words
`default_nettype none
`include "speech_frame_defs.svh"
module speech_transport_end (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   // link
   speech_frame_if.transport          link,
   // user: samples to encoder
   input  wire logic [`SAMPLE_W-1:0]  userSample,
   input  wire logic                  userSampleValid,
   output logic                       userSampleReady,
   // user: coded words to decoder
   input  wire logic [`WORD_W-1:0]    userCode,
   input  wire logic                  userCodeFirst,
   input  wire logic                  userCodeValid,
   output logic                       userCodeReady,
   // user: captured coded words
   output logic [`WORD_W-1:0]         capCode,
   output logic                       capCodeFirst,
   output logic                       capCodeStrobe,
   // user: captured decoder samples
   output logic [`SAMPLE_W-1:0]       capSample,
   output logic                       capSampleStrobe
);
   logic               smpFull;
   logic [`WORD_W-1:0] smpWord;
   logic               codFull;
   logic [`WORD_W-1:0] codWord;
   logic               codFirst;

   // ---------------------------------------------------------------
   // outgoing words, registered
   // ---------------------------------------------------------------
   assign userSampleReady     = !smpFull || link.encSampleReady;
   assign userCodeReady       = !codFull || link.codInReady;
   assign link.encSample      = smpWord;
   assign link.encSampleValid = smpFull;
   assign link.codIn          = codWord;
   assign link.codInValid     = codFull;
   assign link.codInFirst     = codFirst;
   assign link.codOutReady    = 1'b1;
   assign link.decSampleReady = 1'b1;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         smpFull  <= 1'b0;
         smpWord  <= '0;
         codFull  <= 1'b0;
         codWord  <= '0;
         codFirst <= 1'b0;
      end
      else
      begin
         if (userSampleValid && userSampleReady)
         begin
            smpWord <= {userSample, `SAMPLE_PAD_W'(0)};
            smpFull <= 1'b1;
         end
         else if (link.encSampleReady)
            smpFull <= 1'b0;
         if (userCodeValid && userCodeReady)
         begin
            codWord  <= userCode;
            codFirst <= userCodeFirst;
            codFull  <= 1'b1;
         end
         else if (link.codInReady)
            codFull <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // captured words
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         capCode         <= '0;
         capCodeFirst    <= 1'b0;
         capCodeStrobe   <= 1'b0;
         capSample       <= '0;
         capSampleStrobe <= 1'b0;
      end
      else
      begin
         capCodeStrobe   <= link.codOutValid;
         capSampleStrobe <= link.decSampleValid;
         if (link.codOutValid)
         begin
            capCode      <= link.codOut;
            capCodeFirst <= link.codOutFirst;
         end
         if (link.decSampleValid)
            capSample <= link.decSample[`WORD_W-1:`SAMPLE_PAD_W];
      end
   end
endmodule : speech_transport_end
`default_nettype wire

// ==== speech_frame_sva.sv ====
// speech_frame_sva.sv: assertions on the word link between the two ends
// assumes: instanced in tb beside the link, one clock, async high reset
`default_nettype none
`include "speech_frame_defs.svh"
module speech_frame_sva (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // link signals
   input wire logic [15:0] encSample,
   input wire logic        encSampleValid,
   input wire logic [15:0] codOut,
   input wire logic        codOutValid,
   input wire logic        codOutReady,
   input wire logic        codOutFirst,
   input wire logic        codInValid,
   input wire logic        codInReady,
   input wire logic [15:0] decSample,
   input wire logic        decSampleValid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ------
   // word position of coded output
   // ------
   logic [6:0] idxOut;
   logic [6:0] next_idxOut;
   logic [6:0] relOut;
   logic [4:0] posOut;
   logic       isLar;
   logic       isLag;
   assign next_idxOut = (idxOut == 7'h4b) ? 7'h00 : idxOut + 7'h01;
   assign relOut = idxOut - 7'h08;
   assign posOut = 5'(relOut % 7'h11);
   assign isLar = idxOut < 7'h08;
   assign isLag = !isLar && posOut == 5'h00;
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         idxOut <= 7'h00;
      else if (codOutValid && codOutReady)
         idxOut <= next_idxOut;
   end
   // ------
   // properties
   // ------
   property p_enc_pad;
      encSampleValid |-> encSample[2:0] == 3'h0;
   endproperty
   a_enc_pad: assert property (p_enc_pad) else $error("encoder sample low bits set");
   property p_dec_pad;
      decSampleValid |-> decSample[2:0] == 3'h0;
   endproperty
   a_dec_pad: assert property (p_dec_pad) else $error("decoder sample low bits set");
   property p_lar_width;
      codOutValid && isLar |-> (codOut >> (4'h6 - {2'h0, idxOut[2:1]})) == 16'h0000;
   endproperty
   a_lar_width: assert property (p_lar_width) else $error("area-ratio code too wide");
   property p_pulse_width;
      codOutValid && !isLar && posOut >= 5'h04 |-> codOut[15:3] == 13'h0000;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse code too wide");
   property p_gain_grid;
      codOutValid && !isLar && (posOut == 5'h01 || posOut == 5'h02) |-> codOut[15:2] == 14'h0000;
   endproperty
   a_gain_grid: assert property (p_gain_grid) else $error("gain or grid code too wide");
   property p_amp_width;
      codOutValid && !isLar && posOut == 5'h03 |-> codOut[15:6] == 10'h000;
   endproperty
   a_amp_width: assert property (p_amp_width) else $error("amplitude code too wide");
   property p_lag_range;
      codOutValid && isLag |-> codOut >= 16'h0028 && codOut <= 16'h0078;
   endproperty
   a_lag_range: assert property (p_lag_range) else $error("encoder lag out of range");
   property p_frame_start;
      codOutValid |-> codOutFirst == (idxOut == 7'h00);
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start mark misplaced");
   property p_no_stall;
      codInValid [*2] |-> codInReady [*2];
   endproperty
   a_no_stall: assert property (p_no_stall) else $error("decoder input stalled");
endmodule : speech_frame_sva
`default_nettype wire

// ==== tb.sv ====
// tb.sv: bench joining the codec end and the transport end over the link
// assumes: defs header, package, interface, both ends and checker compiled first
`default_nettype none
`include "speech_frame_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, reset;
   logic [12:0] encSampleData, decSampleData, userSample, capSample;
   logic [15:0] encCode, decCode, userCode, capCode;
   logic [6:0]  decodedLagValue;
   logic        encSampleStrobe, encCodeValid, encCodeReady, decCodeStrobe, decFrameDone;
   logic        decSampleValid, decSampleReady, userSampleValid, userSampleReady, userCodeFirst;
   logic        userCodeValid, userCodeReady, capCodeFirst, capCodeStrobe, capSampleStrobe;
   int          failures, n_tests, cycles;
   logic [23:0] encQ[$], capQ[$], decQ[$], smpQ[$];
   logic [12:0] smp[3] = '{13'h1fff, 13'h0001, 13'h0a5a};
   logic [15:0] lagEnc[4] = '{16'h0079, 16'h0027, 16'h0028, 16'h0078};
   logic [15:0] lagEncExp[4] = '{16'h0078, 16'h0028, 16'h0028, 16'h0078};
   logic [15:0] lagDec[4] = '{16'hff00, 16'hff7f, 16'h0027, 16'h0079};
   speech_frame_if link ();
   speech_codec_end #(.FRAME_WORDS(`FRAME_WORDS)) speech_codec_end_inst (
      .core_clk(core_clk), .reset(reset), .link(link.codec),
      .encSampleData(encSampleData), .encSampleStrobe(encSampleStrobe),
      .encCode(encCode), .encCodeValid(encCodeValid), .encCodeReady(encCodeReady),
      .decCode(decCode), .decodedLagValue(decodedLagValue), .decCodeStrobe(decCodeStrobe),
      .decFrameDone(decFrameDone), .decSampleData(decSampleData), .decSampleValid(decSampleValid),
      .decSampleReady(decSampleReady));
   speech_transport_end speech_transport_end_inst (
      .core_clk(core_clk), .reset(reset), .link(link.transport),
      .userSample(userSample), .userSampleValid(userSampleValid), .userSampleReady(userSampleReady),
      .userCode(userCode), .userCodeFirst(userCodeFirst), .userCodeValid(userCodeValid),
      .userCodeReady(userCodeReady), .capCode(capCode), .capCodeFirst(capCodeFirst),
      .capCodeStrobe(capCodeStrobe), .capSample(capSample), .capSampleStrobe(capSampleStrobe));
   speech_frame_sva speech_frame_sva_inst (
      .core_clk(core_clk), .reset(reset), .encSample(link.encSample),
      .encSampleValid(link.encSampleValid), .codOut(link.codOut), .codOutValid(link.codOutValid),
      .codOutReady(link.codOutReady), .codOutFirst(link.codOutFirst), .codInValid(link.codInValid),
      .codInReady(link.codInReady), .decSample(link.decSample), .decSampleValid(link.decSampleValid));
   // ------
   // helpers
   // ------
   function automatic logic [15:0] fieldMask(input int k);
      int pos;
      pos = (k - 8) % 17;
      if (k < 8)
         return (16'h0001 << (6 - k / 2)) - 16'h0001;
      return (pos == 0) ? 16'h007f : (pos == 3) ? 16'h003f : (pos < 3) ? 16'h0003 : 16'h0007;
   endfunction : fieldMask
   function automatic bit isLag(input int k);
      return k >= 8 && (k - 8) % 17 == 0;
   endfunction : isLag
   task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic send_smp(input logic [12:0] s);
      @(negedge core_clk);
      userSample = s;
      userSampleValid = 1'b1;
      do @(posedge core_clk); while (userSampleReady !== 1'b1);
   endtask : send_smp
   task automatic send_enc(input logic [15:0] w);
      @(negedge core_clk);
      encCode = w;
      encCodeValid = 1'b1;
      do @(posedge core_clk); while (encCodeReady !== 1'b1);
   endtask : send_enc
   task automatic send_code(input logic [15:0] w, input logic f);
      @(negedge core_clk);
      userCode = w;
      userCodeFirst = f;
      userCodeValid = 1'b1;
      do @(posedge core_clk); while (userCodeReady !== 1'b1);
   endtask : send_code
   task automatic send_dsp(input logic [12:0] s);
      @(negedge core_clk);
      decSampleData = s;
      decSampleValid = 1'b1;
      do @(posedge core_clk); while (decSampleReady !== 1'b1);
   endtask : send_dsp
   // ------
   // clock, capture, timeout
   // ------
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (encSampleStrobe === 1'b1) encQ.push_back({11'h0, encSampleData});
      if (capCodeStrobe === 1'b1) capQ.push_back({7'h0, capCodeFirst, capCode});
      if (decCodeStrobe === 1'b1) decQ.push_back({decFrameDone, decodedLagValue, decCode});
      if (capSampleStrobe === 1'b1) smpQ.push_back({11'h0, capSample});
      if (cycles == 2000)
      begin
         failures++;
         finish_test();
      end
   end
   // ------
   // main sequence
   // ------
   initial
   begin
      int k;
      logic [15:0] e;
      logic [6:0] lastLag;
      {failures, n_tests, cycles} = '0;
      reset = 1'b1;
      {encCode, encCodeValid, decSampleData, decSampleValid} = '0;
      {userSample, userSampleValid, userCode, userCodeFirst, userCodeValid} = '0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      check("ready lines", 24'h00000f, {20'h0, encCodeReady, decSampleReady, userSampleReady, userCodeReady});
      foreach (smp[i]) send_smp(smp[i]);
      @(negedge core_clk) userSampleValid = 1'b0;
      for (int i = 0; i < 77; i++) send_enc(isLag(i % 76) ? lagEnc[(i % 76 - 8) / 17] : 16'hffff);
      @(negedge core_clk) encCodeValid = 1'b0;
      for (int i = 0; i < 76; i++) send_code(isLag(i) ? lagDec[(i - 8) / 17] : 16'hffff, i == 0);
      @(negedge core_clk) userCodeValid = 1'b0;
      foreach (smp[i]) send_dsp(smp[i]);
      @(negedge core_clk) decSampleValid = 1'b0;
      repeat (10) @(posedge core_clk);
      foreach (smp[i]) check("encoder sample", {11'h0, smp[i]}, encQ[i]);
      foreach (smp[i]) check("decoder sample", {11'h0, smp[i]}, smpQ[i]);
      check("coded word count", 24'd77, 24'(capQ.size()));
      for (int i = 0; i < 77; i++)
      begin
         k = i % 76;
         e = isLag(k) ? lagEncExp[(k - 8) / 17] : fieldMask(k);
         check("coded out word", {7'h0, k == 0, e}, capQ[i]);
      end
      check("decoder word count", 24'd76, 24'(decQ.size()));
      lastLag = 7'h00;
      for (int i = 0; i < 76; i++)
      begin
         if (isLag(i))
            lastLag = lagDec[(i - 8) / 17][6:0];
         e = isLag(i) ? {9'h0, lastLag} : fieldMask(i);
         check("decoder word", {i == 75, lastLag, e}, decQ[i]);
      end
      finish_test();
   end
endmodule : tb
`default_nettype wire
